// ==== timer_channel.sv ====
// one 16-bit down-counting timer channel with register port
//
// Overview of operation
// - two-bit mode field at bits 0 and 1 picks timer, event, one-shot, pwm.
// - the counter is sixteen bits wide.
// - each channel has its own counter, reload, control and interrupt.
// - timer mode counts undivided clock, clock/8, clock/32 or subclock/32.
// - count down; on underflow load the reload value and keep counting.
// - a programmed value n gives one underflow per n+1 source pulses.
// - count while the start flag is 1, hold the count while it is 0.
// - every underflow sets the underflow status bit, which raises the channel interrupt request when its enable bit is set.
// - timer write while stopped loads both reload register and counter.
// - timer write while counting loads only the reload register.
// - reading the timer register returns the live counter value.
// - with gating selected outside event mode, the gate pin enables and disables counting.
// - with pulse output selected, the output pin inverts on each underflow.
// - one-shot mode reloads the counter and stops on the tick that would bring it to zero.
// - event mode counts gate pin edges or another timer's overflow.
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rd_data,
   input wire logic timer_gate_input_pin,
   input wire logic subclock_pin,
   input wire logic other_timer_ovf,
   output logic timer_pulse_output_pin,
   output logic timer_pulse_output_en,
   output logic underflow_out,
   output logic irq
);
   import timer_pkg::*;

   chan_state_t r_r;
   chan_state_t r_nxt;
   logic [1:0] pins_q;
   logic gate_s;
   logic sub_s;
   logic sub_rise;
   logic src_tick;
   logic evt_tick;
   logic cnt_tick;
   logic gate_ok;
   logic cnt_step;
   logic underflow;
   logic oneshot_done;
   logic wr_timer;

   pin_sync #(
      .W(2)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({subclock_pin, timer_gate_input_pin}),
      .q(pins_q)
   );

   assign gate_s = pins_q[0];
   assign sub_s = pins_q[1];
   assign sub_rise = sub_s & ~r_r.sub_prev;
   assign wr_timer = wr_en && (addr == `TMR_OFS_TIMER);

   always_comb
   begin
      case (r_r.clk_sel)
         clock_div_one: src_tick = 1'b1;
         clock_div_eight: src_tick = (r_r.pre[2:0] == `TMR_DIV_EIGHT_LAST);
         clock_div_thirtytwo: src_tick = (r_r.pre == `TMR_DIV_THIRTYTWO_LAST);
         default: src_tick = sub_rise && (r_r.sub_pre == `TMR_DIV_THIRTYTWO_LAST);
      endcase
   end

   // event source: pin edge of chosen polarity or chained overflow
   always_comb
   begin
      if (r_r.evt_src)
      begin
         evt_tick = other_timer_ovf;
      end
      else if (r_r.gate_level)
      begin
         evt_tick = gate_s & ~r_r.evt_prev;
      end
      else
      begin
         evt_tick = ~gate_s & r_r.evt_prev;
      end
   end

   assign cnt_tick = (r_r.mode == event_mode) ? evt_tick : src_tick;

   // gate looked at only on source ticks, level chosen by software
   assign gate_ok = !r_r.gate_en || (r_r.mode == event_mode) || (gate_s == r_r.gate_level);

   assign cnt_step = r_r.start && cnt_tick && gate_ok;

   // zero then one more tick gives underflow
   assign underflow = cnt_step && (r_r.mode != oneshot_mode) && (r_r.cnt == 16'h0000);

   // last tick of one-shot (count at one or zero) reloads the count and clears start
   assign oneshot_done = cnt_step && (r_r.mode == oneshot_mode) && (r_r.cnt <= 16'h0001);

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.ovf = 1'b0;
      r_nxt.rd_data = 16'h0000;
      r_nxt.pre = r_r.pre + 5'h01;
      r_nxt.sub_prev = sub_s;
      r_nxt.evt_prev = gate_s;
      if (sub_rise)
      begin
         r_nxt.sub_pre = r_r.sub_pre + 5'h01;
      end

      if (wr_en)
      begin
         if (addr == `TMR_OFS_MODE)
         begin
            r_nxt.mode = mode_t'(wr_data[`TMR_MODE_HI:`TMR_MODE_LO]);
            r_nxt.gate_en = wr_data[`TMR_GATE_EN_BIT];
            r_nxt.gate_level = wr_data[`TMR_GATE_LEVEL_BIT];
            r_nxt.pulse_en = wr_data[`TMR_PULSE_EN_BIT];
            r_nxt.clk_sel = clk_sel_t'(wr_data[`TMR_CLK_SEL_HI:`TMR_CLK_SEL_LO]);
            r_nxt.evt_src = wr_data[`TMR_EVT_SRC_BIT];
         end
         else if (addr == `TMR_OFS_START)
         begin
            r_nxt.start = wr_data[`TMR_START_BIT];
         end
         else if (addr == `TMR_OFS_TIMER)
         begin
            // split write to reload and counter
            r_nxt.reload = wr_data;
            if (!r_r.start)
            begin
               r_nxt.cnt = wr_data;
            end
         end
         else if (addr == `TMR_OFS_CLEAR)
         begin
            r_nxt.status = r_r.status & ~wr_data[1:0];
         end
         else if (addr == `TMR_OFS_ENABLE)
         begin
            r_nxt.enable = wr_data[1:0];
         end
      end

      if (cnt_step)
      begin
         if (underflow)
         begin
            r_nxt.cnt = r_r.reload;
         end
         else if (oneshot_done)
         begin
            r_nxt.cnt = r_r.reload;
            r_nxt.start = 1'b0;
         end
         else
         begin
            r_nxt.cnt = r_r.cnt - 16'h0001;
         end
      end

      if (underflow && r_r.pulse_en)
      begin
         r_nxt.pulse = ~r_r.pulse;
      end
      r_nxt.ovf = underflow || oneshot_done;

      // sticky status, set wins over clear
      if (underflow)
      begin
         r_nxt.status[`TMR_ST_UNDERFLOW_BIT] = 1'b1;
      end
      if (oneshot_done)
      begin
         r_nxt.status[`TMR_ST_ONESHOT_BIT] = 1'b1;
      end
      r_nxt.irq = |(r_nxt.status & r_nxt.enable);

      if (rd_en)
      begin
         if (addr == `TMR_OFS_MODE)
         begin
            r_nxt.rd_data = {8'h00, r_r.evt_src, r_r.clk_sel, r_r.pulse_en,
               r_r.gate_level, r_r.gate_en, r_r.mode};
         end
         else if (addr == `TMR_OFS_START)
         begin
            r_nxt.rd_data = {15'h0000, r_r.start};
         end
         else if (addr == `TMR_OFS_TIMER)
         begin
            r_nxt.rd_data = r_r.cnt;
         end
         else if (addr == `TMR_OFS_STATUS)
         begin
            r_nxt.rd_data = {14'h0000, r_r.status};
         end
         else if (addr == `TMR_OFS_ENABLE)
         begin
            r_nxt.rd_data = {14'h0000, r_r.enable};
         end
         else
         begin
            r_nxt.rd_data = 16'h0000;
         end
      end
   end

   // private state, all zero after reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         r_r <= `TMR_RST_STATE;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign rd_data = r_r.rd_data;
   assign timer_pulse_output_pin = r_r.pulse;
   assign timer_pulse_output_en = r_r.pulse_en;
   assign underflow_out = r_r.ovf;
   assign irq = r_r.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence write_timer_seq;
      wr_timer;
   endsequence

   sequence underflow_seq;
      r_r.start && cnt_tick && gate_ok && (r_r.mode != oneshot_mode) && (r_r.cnt == 16'h0000);
   endsequence

   sequence stopped_seq;
      !r_r.start && !wr_timer;
   endsequence

   sequence pin_rise_seq;
      r_r.start && (r_r.mode == event_mode) && !r_r.evt_src && r_r.gate_level &&
         $rose(gate_s);
   endsequence

   sequence keep_status_seq;
      r_r.status[0] && !(wr_en && (addr == `TMR_OFS_CLEAR) && wr_data[0]);
   endsequence

   AST_MODE_FIELD: assert property ((wr_en && addr == `TMR_OFS_MODE) |=>
      (r_r.mode == mode_t'($past(wr_data[1:0]))))
      else $error("mode field not taken");

   AST_STOPPED_WRITE: assert property ((write_timer_seq and !r_r.start) |=>
      (r_r.cnt == $past(wr_data)) && (r_r.reload == $past(wr_data)))
      else $error("stopped write did not load counter and reload");

   AST_RUNNING_WRITE: assert property ((write_timer_seq and r_r.start && !cnt_step) |=>
      (r_r.cnt == $past(r_r.cnt)) && (r_r.reload == $past(wr_data)))
      else $error("running write disturbed counter");

   AST_HOLD_STOPPED: assert property (stopped_seq |=> $stable(r_r.cnt))
      else $error("counter moved while stopped");

   AST_DOWN_COUNT: assert property ((cnt_step && r_r.cnt != 16'h0000 &&
      r_r.mode != oneshot_mode) |=> (r_r.cnt == $past(r_r.cnt) - 16'h0001))
      else $error("counter did not step down by one");

   AST_RELOAD: assert property (underflow_seq |=> (r_r.cnt == $past(r_r.reload)))
      else $error("underflow did not reload");

   AST_UNDERFLOW_IRQ: assert property ((underflow_seq ##0 (r_r.enable[0] &&
      !(wr_en && addr == `TMR_OFS_ENABLE))) |=> r_r.status[0] && r_r.irq && underflow_out)
      else $error("underflow raised no interrupt");

   AST_PULSE_TOGGLE: assert property ((underflow_seq ##0 r_r.pulse_en) |=>
      (timer_pulse_output_pin != $past(timer_pulse_output_pin)))
      else $error("pulse output did not invert");

   AST_ONESHOT_STOP: assert property ((oneshot_done && !wr_en) |=> !r_r.start ##1
      (r_r.start || $stable(r_r.cnt) || $past(wr_en)))
      else $error("one-shot kept counting");

   AST_GATE_HOLD: assert property ((r_r.start && !gate_ok && !wr_timer)
      |=> $stable(r_r.cnt))
      else $error("counter moved with gate closed");

   AST_READ_TIMER: assert property ((rd_en && addr == `TMR_OFS_TIMER) |=>
      (rd_data == $past(r_r.cnt)) ##1 (rd_data == 16'h0000 || $past(rd_en)))
      else $error("timer read returned wrong value");

   AST_DIV_EIGHT: assert property ((r_r.clk_sel == clock_div_eight && src_tick) |=>
      (!src_tick || r_r.clk_sel != clock_div_eight) [*7] ##1
      (src_tick || r_r.clk_sel != clock_div_eight))
      else $error("divide-by-eight tick out of place");

   AST_EVENT_EDGE: assert property ((pin_rise_seq ##0 (r_r.cnt != 16'h0000)) |=>
      (r_r.cnt == $past(r_r.cnt) - 16'h0001))
      else $error("pin edge not counted");

   AST_STATUS_STICKY: assert property (keep_status_seq |=> r_r.status[0])
      else $error("underflow status dropped without clear");

   // pulse pin moves only on underflow
   AST_PULSE_HOLD: assert property (!underflow |=> $stable(timer_pulse_output_pin))
      else $error("pulse output moved without underflow");

   AST_RESET_CLEAR: assert property (disable iff (1'b0) !rst_n |=>
      (r_r.cnt == 16'h0000) && (r_r.reload == 16'h0000) && !r_r.start &&
      (r_r.mode == timer_mode) && !timer_pulse_output_pin)
      else $error("reset left channel state behind");
endmodule

// ==== timer_map.svh ====
// register offsets, field positions, reset values and counts of the timer channel
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// register offsets (byte addresses)
`define TMR_OFS_MODE 8'h00
`define TMR_OFS_START 8'h04
`define TMR_OFS_TIMER 8'h08
`define TMR_OFS_STATUS 8'h0c
`define TMR_OFS_CLEAR 8'h10
`define TMR_OFS_ENABLE 8'h14

// mode register fields
`define TMR_MODE_LO 0
`define TMR_MODE_HI 1
`define TMR_GATE_EN_BIT 2
`define TMR_GATE_LEVEL_BIT 3
`define TMR_PULSE_EN_BIT 4
`define TMR_CLK_SEL_LO 5
`define TMR_CLK_SEL_HI 6
`define TMR_EVT_SRC_BIT 7

// start register field
`define TMR_START_BIT 0

// status, clear and enable fields
`define TMR_ST_UNDERFLOW_BIT 0
`define TMR_ST_ONESHOT_BIT 1

// reset values
`define TMR_RST_MODE 8'h00
`define TMR_RST_CNT 16'h0000
`define TMR_RST_RELOAD 16'h0000
`define TMR_RST_STATE '0

// prescaler counts
`define TMR_DIV_EIGHT_LAST 3'h7
`define TMR_DIV_THIRTYTWO_LAST 5'h1f

`endif

// ==== timer_pkg.sv ====
// types of the timer channel
package timer_pkg;

   typedef enum logic [1:0] {
      timer_mode,
      event_mode,
      oneshot_mode,
      pwm_mode
   } mode_t;

   typedef enum logic [1:0] {
      clock_div_one,
      clock_div_eight,
      clock_div_thirtytwo,
      subclock_div_thirtytwo
   } clk_sel_t;

   typedef struct packed {
      mode_t mode;
      logic gate_en;
      logic gate_level;
      logic pulse_en;
      clk_sel_t clk_sel;
      logic evt_src;
      logic start;
      logic [15:0] cnt;
      logic [15:0] reload;
      logic [4:0] pre;
      logic [4:0] sub_pre;
      logic sub_prev;
      logic evt_prev;
      logic [1:0] status;
      logic [1:0] enable;
      logic irq;
      logic pulse;
      logic ovf;
      logic [15:0] rd_data;
   } chan_state_t;

endpackage

// ==== pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_state_t;

   sync_state_t r_r;
   sync_state_t r_nxt;

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.s1 = d;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      // a change counts once stages two and three agree
      for (int i = 0; i < W; i++)
      begin
         if (r_r.s2[i] == r_r.s3[i])
         begin
            r_nxt.q[i] = r_r.s3[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         r_r <= '0;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign q = r_r.q;
endmodule

// ==== timer_pins_model.sv ====
// far-side pin model: drives the gate pin and a slow subclock into the channel
`timescale 1ns/1ps
module timer_pins_model (
   input wire logic clk,
   input wire logic gate_cmd,
   input wire logic sub_run,
   output logic gate_pin,
   output logic sub_pin
);
   logic [2:0] div;
   initial
   begin
      div = 3'h0;
      sub_pin = 1'b0;
   end
   assign gate_pin = gate_cmd;
   // subclock period 8, still when idle
   always @(posedge clk)
   begin
      if (sub_run)
      begin
         div <= div + 3'h1;
         if (div[1:0] == 2'h3)
            sub_pin <= ~sub_pin;
      end
   end
endmodule

// ==== general_timer_down_counter_tb_top.sv ====
// self-checking bench of the timer channel against a period model
`timescale 1ns/1ps
`include "timer_map.svh"
module general_timer_down_counter_tb_top;
   import timer_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic gate_cmd = 1'b0;
   logic sub_run = 1'b0;
   logic ovf = 1'b0;
   logic [15:0] rd_data;
   logic gate_pin, sub_pin, pulse_pin, pulse_en, uf, irq;
   int num_errors = 0;
   int n_checks = 0;
   int exp_q[$];
   int n, p;
   logic [15:0] v, v2;
   always #5 clk = ~clk;
   timer_channel dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .timer_gate_input_pin(gate_pin),
      .subclock_pin(sub_pin), .other_timer_ovf(ovf), .timer_pulse_output_pin(pulse_pin),
      .timer_pulse_output_en(pulse_en), .underflow_out(uf), .irq(irq));
   timer_pins_model pins (.clk(clk), .gate_cmd(gate_cmd), .sub_run(sub_run),
      .gate_pin(gate_pin), .sub_pin(sub_pin));
   task automatic results();
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkp(input int got);
      int e;
      e = exp_q.pop_front();
      n_checks++;
      if (got != e)
      begin
         num_errors++;
         $display("FAIL %0t period %0d expected %0d", $time, got, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   // cycles up to the next underflow pulse
   task automatic wait_uf(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         #1 c++;
      end
      while (uf !== 1'b1 && c < 20000);
      if (c >= 20000)
      begin
         num_errors++;
         $display("FAIL %0t no underflow", $time);
         results();
      end
   endtask
   initial
   begin
      void'($urandom(32'h1873911f));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`TMR_OFS_MODE, v);
      chk(v, 16'h0000);
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'h0000);
      chk({15'h0, pulse_pin}, 16'h0000);
      rd(8'h40, v);
      chk(v, 16'h0000);
      n = 2 + int'($urandom % 32'd11);
      wr(`TMR_OFS_TIMER, 16'(n));
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'(n));
      wr(`TMR_OFS_ENABLE, 16'h0001);
      for (int s = 0; s < 4; s++)
      begin
         wr(`TMR_OFS_MODE, 16'(s << 5));
         sub_run <= (s == 3);
         wr(`TMR_OFS_START, 16'h0001);
         exp_q.push_back((n + 1) * (s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 256));
         wait_uf(p);
         wait_uf(p);
         chkp(p);
      end
      chk({15'h0, irq}, 16'h0001);
      wr(`TMR_OFS_MODE, 16'h0010);
      wait_uf(p);
      v2 = {15'h0, pulse_pin};
      wait_uf(p);
      exp_q.push_back(n + 1);
      chkp(p);
      chk({15'h0, pulse_pin}, {15'h0, ~v2[0]});
      chk({15'h0, pulse_en}, 16'h0001);
      wr(`TMR_OFS_TIMER, 16'(n + 7));
      wait_uf(p);
      chk(16'(p <= n + 1), 16'h0001);
      exp_q.push_back(n + 8);
      wait_uf(p);
      chkp(p);
      wr(`TMR_OFS_START, 16'h0000);
      rd(`TMR_OFS_TIMER, v);
      repeat (5) @(posedge clk);
      rd(`TMR_OFS_TIMER, v2);
      chk(v2, v);
      wr(`TMR_OFS_CLEAR, 16'h0003);
      rd(`TMR_OFS_STATUS, v);
      chk(v, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(`TMR_OFS_TIMER, 16'(n));
      wr(`TMR_OFS_MODE, 16'h000c);
      wr(`TMR_OFS_START, 16'h0001);
      repeat (20) @(posedge clk);
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'(n));
      @(posedge clk);
      gate_cmd <= 1'b1;
      wait_uf(p);
      exp_q.push_back(n + 1);
      wait_uf(p);
      chkp(p);
      wr(`TMR_OFS_START, 16'h0000);
      wr(`TMR_OFS_TIMER, 16'h0004);
      wr(`TMR_OFS_MODE, 16'h0002);
      wr(`TMR_OFS_START, 16'h0001);
      wait_uf(p);
      rd(`TMR_OFS_START, v);
      chk(v, 16'h0000);
      rd(`TMR_OFS_STATUS, v);
      chk({15'h0, v[1]}, 16'h0001);
      wr(`TMR_OFS_TIMER, 16'h0003);
      wr(`TMR_OFS_MODE, 16'h0081);
      rd(`TMR_OFS_MODE, v);
      chk(v, 16'h0081);
      wr(`TMR_OFS_START, 16'h0001);
      repeat (2)
      begin
         @(posedge clk);
         ovf <= 1'b1;
         @(posedge clk);
         ovf <= 1'b0;
      end
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'h0001);
      // pin edges: rising edges first, then falling edges
      for (int lv = 1; lv >= 0; lv--)
      begin
         wr(`TMR_OFS_START, 16'h0000);
         wr(`TMR_OFS_TIMER, 16'h0005);
         wr(`TMR_OFS_MODE, 16'(1 + 8 * lv));
         wr(`TMR_OFS_START, 16'h0001);
         repeat (3)
         begin
            gate_cmd <= 1'b0;
            repeat (6) @(posedge clk);
            gate_cmd <= 1'b1;
            repeat (6) @(posedge clk);
         end
         rd(`TMR_OFS_TIMER, v);
         chk(v, 16'(5 - 3));
      end
      // active-low gate in pwm mode
      wr(`TMR_OFS_START, 16'h0000);
      wr(`TMR_OFS_TIMER, 16'(n));
      wr(`TMR_OFS_MODE, 16'h0007);
      wr(`TMR_OFS_START, 16'h0001);
      repeat (10) @(posedge clk);
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'(n));
      @(posedge clk);
      gate_cmd <= 1'b0;
      wait_uf(p);
      exp_q.push_back(n + 1);
      wait_uf(p);
      chkp(p);
      // second reset while running with the pulse pin high
      wr(`TMR_OFS_MODE, 16'h0010);
      wait_uf(p);
      chk({15'h0, pulse_pin}, 16'h0001);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`TMR_OFS_MODE, v);
      chk(v, 16'h0000);
      rd(`TMR_OFS_START, v);
      chk(v, 16'h0000);
      rd(`TMR_OFS_TIMER, v);
      chk(v, 16'h0000);
      chk({15'h0, pulse_pin}, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(`TMR_OFS_START, 16'h0001);
      exp_q.push_back(0 + 1);
      wait_uf(p);
      wait_uf(p);
      chkp(p);
      results();
   end
endmodule
